// >>> design/swp_pkg.sv
// package: shared constants and types for the single-wire bit coding ends
package swp_pkg;
  // ==========================================================================
  // clock and bit timing
  // ==========================================================================
  localparam int REF_CLK_MHZ = 200;
  // default bit period in ns (master side)
  localparam int BIT_PERIOD_NS = 1000;
  localparam int BIT_PERIOD_CYC = BIT_PERIOD_NS * REF_CLK_MHZ / 1000;
  // high time for one is 3/4, for zero 1/4 of the period
  localparam int HIGH_ONE_CYC = BIT_PERIOD_CYC * 3 / 4;
  localparam int HIGH_ZERO_CYC = BIT_PERIOD_CYC / 4;
  // default range 1..5 us, extended 0.590..10 us, in ns
  localparam int MIN_DEF_NS = 1000;
  localparam int MAX_DEF_NS = 5000;
  localparam int MIN_EXT_NS = 590;
  localparam int MAX_EXT_NS = 10000;
  localparam int MIN_DEF_CYC = (MIN_DEF_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int MAX_DEF_CYC = MAX_DEF_NS * REF_CLK_MHZ / 1000;
  localparam int MIN_EXT_CYC = (MIN_EXT_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int MAX_EXT_CYC = MAX_EXT_NS * REF_CLK_MHZ / 1000;
  // resume by slave answer time in ns
  localparam int RESUME_MAX_NS = 5000;
  localparam int RESUME_MAX_CYC = RESUME_MAX_NS * REF_CLK_MHZ / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

  typedef enum logic [1:0]
  {
    SWP_ST_PAUSED = 2'b00,
    SWP_ST_HIGH = 2'b01,
    SWP_ST_LOW = 2'b10
  } swp_mst_state_t;
endpackage : swp_pkg

// >>> design/swp_link_if.sv
// interface: the single shared contact between master and slave
`timescale 1ns/10ps
interface swp_link_if;
  logic master_voltage_line;
  logic slave_current_signal;
  modport master
  (
    output master_voltage_line,
    input slave_current_signal
  );
  modport slave
  (
    input master_voltage_line,
    output slave_current_signal
  );
endinterface : swp_link_if

// >>> design/swp_slave.sv
// module: card module slave end of the single-wire bit coding
// Contract
// (RULE1) master sends voltage, slave returns current
// (RULE2) bit spans rising edge to rising edge
// (RULE3) bits back to back, each measured alone
// (RULE4) master one: high 0.70..0.80 of T
// (RULE5) master zero: high 0.20..0.30 of T
// (RULE6) period 1..5 us, extended 0.590..10 us
// (RULE7) master samples current only while high
// (RULE8) slave switches current only while line low
// (RULE9) paused: line high, current low, no edges
// (RULE10) slave resumes by current, master answers 5us
// (RULE11) master sends idle zeros between frames
// (RULE12) slave decodes: high time over half period
`timescale 1ns/10ps
module swp_slave
(
  input wire logic ref_clk,
  input wire logic rst_n,
  swp_link_if.slave link,
  input wire logic extended_rate,
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_taken,
  input wire logic resume_req,
  output logic rx_bit,
  output logic rx_valid,
  output logic period_error,
  output logic line_paused
);
  // ==========================================================================
  // line synchroniser
  // ==========================================================================
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic line_lvl;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // reset to the idle high level, so leaving reset fakes no rising edge
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end
    else
    begin
      sync_a <= link.master_voltage_line;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // a change counts once the last two stages agree
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_lvl <= 1'b1;
    else if (sync_b == sync_c)
      line_lvl <= sync_c;
  end

  logic line_d;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_d <= 1'b1;
    else
      line_d <= line_lvl;
  end
  logic rise;
  logic fall;
  assign rise = line_lvl && !line_d; // see (RULE2)
  assign fall = !line_lvl && line_d;

  // ==========================================================================
  // per-bit measurement
  // ==========================================================================
  logic [swp_pkg::CNT_W-1:0] period_cnt;
  logic [swp_pkg::CNT_W-1:0] high_cnt;
  logic seen_rise;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      period_cnt <= swp_pkg::CNT_RESET;
      high_cnt <= swp_pkg::CNT_RESET;
      seen_rise <= 1'b0;
    end
    else if (rise)
    begin
      // each bit measured on its own, no averaging
      period_cnt <= 12'h001; // see (RULE3)
      seen_rise <= 1'b1;
    end
    else
    begin
      // a pause has no opening edge, so the next rise only starts a bit
      if (line_paused)
        seen_rise <= 1'b0;
      if (period_cnt != 12'hfff)
        period_cnt <= period_cnt + 12'h001;
      if (fall)
        high_cnt <= period_cnt;
    end
  end

  // ==========================================================================
  // decode at the closing rising edge
  // ==========================================================================
  logic [swp_pkg::CNT_W-1:0] min_cyc;
  logic [swp_pkg::CNT_W-1:0] max_cyc;
  // both bounds follow the same rate choice, so one function serves both
  function automatic logic [swp_pkg::CNT_W-1:0] rate_bound
  (
    input logic ext,
    input logic upper
  );
    logic [swp_pkg::CNT_W-1:0] bound;
    if (upper)
      bound = ext ? swp_pkg::MAX_EXT_CYC[swp_pkg::CNT_W-1:0]
                  : swp_pkg::MAX_DEF_CYC[swp_pkg::CNT_W-1:0];
    else
      bound = ext ? swp_pkg::MIN_EXT_CYC[swp_pkg::CNT_W-1:0]
                  : swp_pkg::MIN_DEF_CYC[swp_pkg::CNT_W-1:0];
    return bound;
  endfunction : rate_bound

  assign min_cyc = rate_bound(extended_rate, 1'b0);
  assign max_cyc = rate_bound(extended_rate, 1'b1);

  // doubling the high time avoids a divider for the half-period compare
  function automatic logic decode_one
  (
    input logic [swp_pkg::CNT_W-1:0] high,
    input logic [swp_pkg::CNT_W-1:0] period
  );
    return {high, 1'b0} > {1'b0, period};
  endfunction : decode_one

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_bit <= 1'b0;
      rx_valid <= 1'b0;
      period_error <= 1'b0;
    end
    else
    begin
      rx_valid <= rise && seen_rise;
      if (rise && seen_rise)
      begin
        rx_bit <= decode_one(high_cnt, period_cnt); // see (RULE12)
        period_error <= (period_cnt < min_cyc) || (period_cnt > max_cyc); // see (RULE6)
      end
    end
  end

  // line high past the longest period since the last rise means the link is paused
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_paused <= 1'b0;
    else
      line_paused <= line_lvl && (period_cnt > max_cyc); // see (RULE9)
  end

  // ==========================================================================
  // current return
  // ==========================================================================
  logic drive;
  logic pend_bit;
  logic pend;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend <= 1'b0;
      pend_bit <= 1'b0;
      tx_taken <= 1'b0;
    end
    else
    begin
      tx_taken <= tx_valid && !pend;
      if (tx_valid && !pend)
      begin
        pend <= 1'b1;
        pend_bit <= tx_bit;
      end
      else if (fall)
        pend <= 1'b0;
    end
  end

  // switch data current only in the low phase, so the master sees a stable level while high;
  // a resume current is held until the master pulls the line low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      drive <= 1'b0;
    else if (fall)
      drive <= pend && pend_bit; // see (RULE8)
    else if (line_paused && resume_req)
      drive <= 1'b1; // see (RULE10)
  end
  assign link.slave_current_signal = drive; // see (RULE1)
endmodule : swp_slave

// >>> design/swp_master.sv
// module: contactless front-end master end of the single-wire bit coding
`timescale 1ns/10ps
module swp_master
(
  input wire logic ref_clk,
  input wire logic rst_n,
  swp_link_if.master link,
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_taken,
  input wire logic pause_req,
  output logic rx_bit,
  output logic rx_valid,
  output logic paused
);
  // ==========================================================================
  // current input synchroniser
  // ==========================================================================
  logic sa;
  logic sb;
  logic sc;
  logic cur;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sa <= 1'b0;
      sb <= 1'b0;
      sc <= 1'b0;
      cur <= 1'b0;
    end
    else
    begin
      sa <= link.slave_current_signal;
      sb <= sa;
      sc <= sb;
      if (sb == sc)
        cur <= sc;
    end
  end

  // ==========================================================================
  // bit generator
  // ==========================================================================
  swp_pkg::swp_mst_state_t state;
  logic [swp_pkg::CNT_W-1:0] cnt;
  logic [swp_pkg::CNT_W-1:0] high_len;
  logic line;
  logic sampled;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= swp_pkg::SWP_ST_PAUSED;
      cnt <= swp_pkg::CNT_RESET;
      high_len <= swp_pkg::HIGH_ZERO_CYC[swp_pkg::CNT_W-1:0];
      line <= 1'b1;
      tx_taken <= 1'b0;
    end
    else
    begin
      tx_taken <= 1'b0;
      case (state)
        swp_pkg::SWP_ST_PAUSED:
        begin
          line <= 1'b1; // see (RULE9)
          if (cur || !pause_req)
          begin
            // answer a resume at once, well inside the limit
            state <= swp_pkg::SWP_ST_HIGH; // see (RULE10)
            line <= 1'b0;
            cnt <= swp_pkg::CNT_RESET;
            high_len <= swp_pkg::HIGH_ZERO_CYC[swp_pkg::CNT_W-1:0];
          end
        end
        swp_pkg::SWP_ST_HIGH:
        begin
          cnt <= cnt + 12'h001;
          if (cnt == swp_pkg::CNT_RESET)
            line <= 1'b1;
          else if (cnt == high_len)
          begin
            line <= 1'b0;
            state <= swp_pkg::SWP_ST_LOW;
          end
        end
        swp_pkg::SWP_ST_LOW:
        begin
          cnt <= cnt + 12'h001;
          if (cnt == swp_pkg::BIT_PERIOD_CYC[swp_pkg::CNT_W-1:0])
          begin
            cnt <= 12'h001;
            if (pause_req && !tx_valid)
            begin
              line <= 1'b1;
              state <= swp_pkg::SWP_ST_PAUSED;
            end
            else
            begin
              line <= 1'b1; // see (RULE2) (RULE3)
              state <= swp_pkg::SWP_ST_HIGH;
              tx_taken <= tx_valid;
              // idle zero when nothing waits
              high_len <= (tx_valid && tx_bit)
                ? swp_pkg::HIGH_ONE_CYC[swp_pkg::CNT_W-1:0] // see (RULE4)
                : swp_pkg::HIGH_ZERO_CYC[swp_pkg::CNT_W-1:0]; // see (RULE5) (RULE11)
            end
          end
        end
        default:
          state <= swp_pkg::SWP_ST_PAUSED;
      endcase
    end
  end
  assign link.master_voltage_line = line; // see (RULE1) (RULE6)

  // ==========================================================================
  // return sampling
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sampled <= 1'b0;
      rx_bit <= 1'b0;
      rx_valid <= 1'b0;
      paused <= 1'b1;
    end
    else
    begin
      paused <= (state == swp_pkg::SWP_ST_PAUSED);
      rx_valid <= 1'b0;
      // take current mid way through the high phase only
      if (state == swp_pkg::SWP_ST_HIGH && cnt == {1'b0, high_len[swp_pkg::CNT_W-1:1]})
        sampled <= cur; // see (RULE7)
      if (state == swp_pkg::SWP_ST_HIGH && cnt == high_len)
      begin
        rx_bit <= sampled;
        rx_valid <= 1'b1;
      end
    end
  end
endmodule : swp_master

// >>> verification/swp_link_assertions.sv
// checker: timing relations on the single-wire contact
`timescale 1ns/10ps
module swp_link_assertions
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic master_voltage_line,
  input wire logic slave_current_signal
);
  localparam int RESUME_WAIT = swp_pkg::RESUME_MAX_CYC;
  logic [11:0] hcnt;
  logic [11:0] lcnt;
  logic [11:0] hlast;
  logic [1:0] nr;
  // ==========================================================================
  // helper counters
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !master_voltage_line)
      hcnt <= 12'h000;
    else if (hcnt != 12'hfff)
      hcnt <= hcnt + 12'h001;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || master_voltage_line)
      lcnt <= 12'h000;
    else if (lcnt != 12'hfff)
      lcnt <= lcnt + 12'h001;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!master_voltage_line && hcnt != 12'h000)
      hlast <= hcnt;
  end
  // first edges after a pause belong to the resume sequence, not to data
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || hcnt > swp_pkg::MAX_DEF_CYC)
      nr <= 2'h0;
    else if ($rose(master_voltage_line) && nr != 2'h3)
      nr <= nr + 2'h1;
  end
  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_reset_idle_line: assert property ($rose(rst_n) |->
    master_voltage_line && !slave_current_signal) else $error("line not idle after reset");
  a_high_time_code: assert property ($fell(master_voltage_line) && nr == 2'h3 |->
    hcnt == swp_pkg::HIGH_ONE_CYC || hcnt == swp_pkg::HIGH_ZERO_CYC)
    else $error("high time codes no bit");
  a_bit_period_len: assert property ($rose(master_voltage_line) && nr == 2'h3 |->
    hlast + lcnt == swp_pkg::BIT_PERIOD_CYC) else $error("bit period wrong");
  a_min_high_run: assert property ($rose(master_voltage_line) && nr == 2'h3 |->
    master_voltage_line[*8]) else $error("high phase too short");
  a_current_switch_low: assert property ($changed(slave_current_signal) |->
    !master_voltage_line || hcnt > swp_pkg::MAX_DEF_CYC) else $error("current switched while high");
  a_resume_wait: assert property ($rose(slave_current_signal) && master_voltage_line |->
    ##[1:RESUME_WAIT] !master_voltage_line) else $error("no answer to resume");
  a_resume_hold: assert property ($rose(slave_current_signal) && master_voltage_line |->
    slave_current_signal until !master_voltage_line) else $error("resume current dropped");
  a_resume_from_pause: assert property ($rose(slave_current_signal) && master_voltage_line |->
    hcnt > swp_pkg::MAX_DEF_CYC) else $error("current raised outside pause");
endmodule : swp_link_assertions

// >>> verification/tb.sv
// testbench: both ends joined, random bits both ways, pause and resume
`timescale 1ns/10ps
module tb;
  logic ref_clk, rst_n, m_bit, m_valid, m_taken, pause_req, m_rx, m_rxv, paused;
  logic s_bit, s_valid, s_taken, ext, resume_req, s_rx, s_rxv, s_err, s_paused;
  logic [31:0] seed;
  int error_cnt, checked;
  logic m_q[$], s_q[$], m_got[$], s_got[$];
  swp_link_if swp_link_if_inst();
  swp_master swp_master_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(swp_link_if_inst),
    .tx_bit(m_bit), .tx_valid(m_valid), .tx_taken(m_taken), .pause_req(pause_req),
    .rx_bit(m_rx), .rx_valid(m_rxv), .paused(paused));
  swp_slave swp_slave_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(swp_link_if_inst),
    .extended_rate(ext), .tx_bit(s_bit), .tx_valid(s_valid), .tx_taken(s_taken),
    .resume_req(resume_req), .rx_bit(s_rx), .rx_valid(s_rxv), .period_error(s_err),
    .line_paused(s_paused));
  swp_link_assertions swp_link_assertions_inst(.ref_clk(ref_clk), .rst_n(rst_n),
    .master_voltage_line(swp_link_if_inst.master_voltage_line),
    .slave_current_signal(swp_link_if_inst.slave_current_signal));
  // ==========================================================================
  // helpers
  function automatic logic rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[0];
  endfunction : rnd
  task automatic check(logic seen, logic exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, seen, exp);
    end
  endtask : check
  // the receiver sees a few idle bits before the first sent one
  function automatic int find_off(logic sent[$], logic got[$]);
    for (int o = 0; o < 6; o++)
    begin
      int ok;
      ok = 1;
      for (int i = 0; i < 16; i++)
        if (got[o+i] !== sent[i]) ok = 0;
      if (ok) return o;
    end
    return 0;
  endfunction : find_off
  task automatic cmp_stream(logic sent[$], logic got[$]);
    int o;
    o = find_off(sent, got);
    check(got.size() > 40, 1'b1);
    for (int i = 0; i + o < got.size() && i < sent.size(); i++)
      check(got[i+o], sent[i]);
  endtask : cmp_stream
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ==========================================================================
  // clock, collectors, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (m_taken) m_q.push_back(m_bit);
    if (m_taken) m_bit <= rnd();
    if (s_taken) s_q.push_back(s_bit);
    if (s_taken) s_bit <= rnd();
    if (m_rxv) m_got.push_back(m_rx);
    if (s_rxv) s_got.push_back(s_rx);
    if (s_rxv) check(s_err, 1'b0);
  end
  initial
  begin
    #150000;
    error_cnt++;
    summarize();
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 32'hef167cf1;
    {rst_n, m_valid, pause_req, s_valid, ext, resume_req} = 6'h00;
    m_bit = rnd();
    s_bit = rnd();
    repeat (5) @(posedge ref_clk);
    check(paused, 1'b1);
    check(swp_link_if_inst.master_voltage_line, 1'b1);
    rst_n <= 1'b1;
    m_valid <= 1'b1;
    s_valid <= 1'b1;
    repeat (9600) @(posedge ref_clk);
    m_valid <= 1'b0;
    s_valid <= 1'b0;
    repeat (600) @(posedge ref_clk);
    cmp_stream(m_q, s_got);
    cmp_stream(s_q, m_got);
    $display("test streams done");
    ext <= 1'b1;
    pause_req <= 1'b1;
    repeat (2400) @(posedge ref_clk);
    check(paused, 1'b1);
    check(s_paused, 1'b1);
    check(swp_link_if_inst.slave_current_signal, 1'b0);
    resume_req <= 1'b1;
    for (int i = 0; i < 1200 && paused !== 1'b0; i++) @(posedge ref_clk);
    check(paused, 1'b0);
    $display("test pause and resume done");
    resume_req <= 1'b0;
    pause_req <= 1'b0;
    s_got.delete();
    repeat (2000) @(posedge ref_clk);
    check(s_got.size() > 5, 1'b1);
    for (int i = 3; i < s_got.size(); i++) check(s_got[i], 1'b0);
    $display("test idle bits done");
    summarize();
  end
endmodule : tb
